// ===== hpt_pkg.sv
// Constants for the hashed page-table address generator and walker.
// Assumes big-endian field numbering has been mapped to LSB-0 here.
package hpt_pkg;
    // Bus and address widths
    localparam int EA_W = 64;
    localparam int VA_W = 80;
    localparam int PA_W = 64;
    localparam int OFS_W = 12;
    localparam int PI_W = 16;
    // 32-bit variant layout
    localparam int SEG_CNT = 16;
    localparam int SEG_IDX_W = 4;
    localparam int SEGID32_W = 24;
    localparam int HASH32_W = 19;
    localparam int LOW32_W = 10;
    localparam int ABPI32_W = 6;
    localparam int MASK32_W = 9;
    localparam int ORG32_LSB = 16;
    localparam int GRP32_ZEROS = 6;
    localparam int ADDR32_W = 32;
    // 64-bit variant layout
    localparam int SEL64_W = 36;
    localparam int SEGID64_W = 52;
    localparam int HASH64_W = 39;
    localparam int LOW64_W = 11;
    localparam int ABPI64_W = 5;
    localparam int MASK64_W = 18;
    localparam int SIZE64_W = 5;
    localparam int ORG64_LSB = 18;
    localparam int GRP64_ZEROS = 7;
    // Merged-bit count width
    localparam int CNT_W = 5;
    // Group walk
    localparam int GROUP_ENTRIES = 8;
    localparam int IDX_W = 3;
    localparam logic [PA_W-1:0] STRIDE32 = 64'h8;
    localparam logic [PA_W-1:0] STRIDE64 = 64'h10;
    // 32-bit entry first word, LSB-0
    localparam int E32_VALID = 31;
    localparam int E32_SEGID_LSB = 7;
    localparam int E32_HSEL = 6;
    localparam int E32_ABPI_LSB = 0;
    // 64-bit entry first doubleword, LSB-0
    localparam int E64_SEGID_LSB = 12;
    localparam int E64_ABPI_LSB = 7;
    localparam int E64_HSEL = 1;
    localparam int E64_VALID = 0;

    // Walker states, one-hot
    typedef enum logic [3:0] {
        HPT_IDLE = 4'b0001,
        HPT_SEG = 4'b0010,
        HPT_ADDR = 4'b0100,
        HPT_READ = 4'b1000
    } hpt_state_e;
endpackage : hpt_pkg

// ===== hpt_hash_unit.sv
// Combinational virtual-address build, hash and group address generation.
// Assumes latched effective address, segment identifier and descriptor.
module hpt_hash_unit #(
    parameter bit WIDE64 = 1'b0
) (
    input wire logic [hpt_pkg::EA_W-1:0] effAddr,
    input wire logic [hpt_pkg::SEGID64_W-1:0] segId,
    input wire logic [hpt_pkg::PA_W-1:0] descReg,
    input wire logic secondary,
    output logic [hpt_pkg::VA_W-1:0] virtAddr,
    output logic [hpt_pkg::PA_W-1:0] groupAddr,
    output logic [hpt_pkg::PA_W-1:0] tableBase,
    output logic [hpt_pkg::ABPI32_W-1:0] abbrevPageIndex,
    output logic [hpt_pkg::CNT_W-1:0] mergeBits
);
    import hpt_pkg::*;

    if (WIDE64) begin : g_wide
        logic [HASH64_W-1:0] hash;
        logic [MASK64_W-1:0] mask;
        logic [PI_W-1:0] pageIdx;
        assign pageIdx = effAddr[OFS_W +: PI_W];
        // Size field is a count of mask ones, one compare per bit
        for (genvar i = 0; i < MASK64_W; i++) begin : g_mask
            assign mask[i] = (descReg[SIZE64_W-1:0] > SIZE64_W'(i));
        end
        // Secondary hash is the complement of the primary [RL13]
        assign hash = segId[HASH64_W-1:0]
            ^ {{(HASH64_W-PI_W){1'b0}}, pageIdx}
            ^ {HASH64_W{secondary}}; // [RL6] [RL8] [RL13]
        assign virtAddr = {segId, effAddr[EA_W-SEL64_W-1:0]}; // [RL5]
        // Masked hash ORed into origin; zeroed origin bits are assumed [RL3]
        assign groupAddr = {descReg[PA_W-1:ORG64_LSB+MASK64_W],
            descReg[ORG64_LSB +: MASK64_W] | (hash[LOW64_W +: MASK64_W] & mask),
            hash[LOW64_W-1:0], {GRP64_ZEROS{1'b0}}}; // [RL7]
        assign tableBase = {descReg[PA_W-1:ORG64_LSB], {ORG64_LSB{1'b0}}};
        assign abbrevPageIndex = {1'b0, pageIdx[PI_W-1 -: ABPI64_W]}; // [RL8]
        assign mergeBits = CNT_W'($countones(mask)); // [RL16]
    end else begin : g_narrow
        logic [HASH32_W-1:0] hash;
        logic [MASK32_W-1:0] mask;
        logic [PI_W-1:0] pageIdx;
        assign pageIdx = effAddr[OFS_W +: PI_W];
        assign mask = descReg[MASK32_W-1:0];
        assign hash = segId[HASH32_W-1:0]
            ^ {{(HASH32_W-PI_W){1'b0}}, pageIdx}
            ^ {HASH32_W{secondary}}; // [RL10] [RL12] [RL13]
        assign virtAddr = {{(VA_W-SEGID32_W-ADDR32_W+SEG_IDX_W){1'b0}},
            segId[SEGID32_W-1:0],
            effAddr[ADDR32_W-SEG_IDX_W-1:0]}; // [RL9]
        // Upper hash bits merge into origin under the mask [RL3]
        assign groupAddr = {{(PA_W-ADDR32_W){1'b0}},
            descReg[ADDR32_W-1:ORG32_LSB+MASK32_W],
            descReg[ORG32_LSB +: MASK32_W] | (hash[LOW32_W +: MASK32_W] & mask),
            hash[LOW32_W-1:0], {GRP32_ZEROS{1'b0}}}; // [RL11] [RL2]
        assign tableBase = {{(PA_W-ADDR32_W){1'b0}},
            descReg[ADDR32_W-1:ORG32_LSB], {ORG32_LSB{1'b0}}}; // [RL1]
        assign abbrevPageIndex = pageIdx[PI_W-1 -: ABPI32_W]; // [RL12]
        assign mergeBits = CNT_W'($countones(mask)); // [RL16]
    end
endmodule : hpt_hash_unit

// ===== hpt_addr_gen.sv
// Hashed page-table walker: segment lookup, group addressing and search.
// Assumes a memory read port that answers memReq with a one-cycle memAck
// carrying the entry's first word (32-bit) or doubleword (64-bit) in
// memData, and, in the 64-bit variant, an outside segment lookup that
// returns segDesc64 combinationally for segSelect.
//
// Contract
// RL1: 32-bit table base is origin plus 16 zeros
// RL2: 32-bit group address low six bits zero
// RL3: Software zeroes origin bits under size mask
// RL4: Primary takes H clear, secondary H set
// RL5: 64-bit: 36 EA bits pick descriptor, 80-bit VA
// RL6: 64-bit hash: VA 13-51 XOR 52-67
// RL7: 64-bit group: masked hash OR origin, seven zeros
// RL8: 64-bit: 11 index bits hashed, 5-bit compare
// RL9: 32-bit: top four bits pick segment, 52-bit VA
// RL10: 32-bit hash: VA 5-23 XOR 24-39
// RL11: 32-bit group: masked hash OR origin, six zeros
// RL12: 32-bit: 10 index bits hashed, 6-bit compare
// RL13: Secondary hash is complement of primary
// RL14: Hit needs valid, identifier, index, proper H
// RL15: Up to sixteen entries, else page fault
// RL16: Merge width from mask; width by parameter
// RL17: Secondary address only after primary miss
module hpt_addr_gen #(
    parameter bit WIDE64 = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    // Segment register writes (32-bit variant)
    input wire logic segWrEn,
    input wire logic [hpt_pkg::SEG_IDX_W-1:0] segWrIndex,
    input wire logic [hpt_pkg::SEGID32_W-1:0] segWrData,
    // Table descriptor register write
    input wire logic descWrEn,
    input wire logic [hpt_pkg::PA_W-1:0] descWrData,
    // Search request
    input wire logic searchStart,
    input wire logic [hpt_pkg::EA_W-1:0] effAddr,
    output logic searchBusy,
    // Segment descriptor lookup (64-bit variant)
    output logic [hpt_pkg::SEL64_W-1:0] segSelect,
    input wire logic [hpt_pkg::SEGID64_W-1:0] segDesc64,
    // Memory read port
    output logic memReq,
    output logic [hpt_pkg::PA_W-1:0] memAddr,
    input wire logic memAck,
    input wire logic [hpt_pkg::PA_W-1:0] memData,
    // Results
    output logic hitPulse,
    output logic faultPulse,
    output logic hitSecondary,
    output logic [hpt_pkg::PA_W-1:0] hitEntryData,
    output logic [hpt_pkg::PA_W-1:0] hitEntryAddr,
    output logic [hpt_pkg::VA_W-1:0] virtAddr,
    output logic [hpt_pkg::PA_W-1:0] tableBase,
    output logic [hpt_pkg::PA_W-1:0] primaryGroupAddr,
    output logic [hpt_pkg::CNT_W-1:0] mergeBitCount,
    output logic [hpt_pkg::PA_W-1:0] descReadback
);
    import hpt_pkg::*;

    localparam logic [PA_W-1:0] STRIDE = WIDE64 ? STRIDE64 : STRIDE32;

    hpt_state_e state_ff;
    hpt_state_e nxt_state;
    logic [SEGID32_W-1:0] segRegs_ff [SEG_CNT];
    logic [PA_W-1:0] desc_ff;
    logic [EA_W-1:0] ea_ff;
    logic [SEGID64_W-1:0] segId_ff;
    logic secondary_ff;
    logic [IDX_W-1:0] idx_ff;
    logic [PA_W-1:0] memAddr_ff;
    logic hit_ff;
    logic fault_ff;
    logic hitSec_ff;
    logic [PA_W-1:0] hitData_ff;
    logic [PA_W-1:0] hitAddr_ff;
    logic [VA_W-1:0] va_ff;
    logic [PA_W-1:0] base_ff;
    logic [PA_W-1:0] priGrp_ff;
    logic [CNT_W-1:0] mergeCnt_ff;

    logic [VA_W-1:0] vaNow;
    logic [PA_W-1:0] grpNow;
    logic [PA_W-1:0] baseNow;
    logic [ABPI32_W-1:0] pageKeyNow;
    logic [CNT_W-1:0] mergeNow;
    logic entryMatch;
    logic lastEntry;
    logic [SEGID64_W-1:0] segPick;

    // Address arithmetic kept apart so the walker stays readable
    hpt_hash_unit #(
        .WIDE64(WIDE64)
    ) u_hash (
        .effAddr(ea_ff),
        .segId(segId_ff),
        .descReg(desc_ff),
        .secondary(secondary_ff),
        .virtAddr(vaNow),
        .groupAddr(grpNow),
        .tableBase(baseNow),
        .abbrevPageIndex(pageKeyNow),
        .mergeBits(mergeNow)
    );

    // Segment registers, written by software
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SEG_CNT; i++) begin
                segRegs_ff[i] <= '0;
            end
        end else if (segWrEn) begin
            segRegs_ff[segWrIndex] <= segWrData;
        end
    end

    // Table descriptor; a write during a walk would tear the addresses
    // of one search, so it is dropped unless the walker is idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            desc_ff <= '0;
        end else if (descWrEn && state_ff == HPT_IDLE) begin
            desc_ff <= WIDE64 ? descWrData
                : {{(PA_W-ADDR32_W){1'b0}}, descWrData[ADDR32_W-1:0]};
        end
    end

    // Segment selection by the top effective-address bits
    always_comb begin
        if (WIDE64) begin
            segSelect = ea_ff[EA_W-1 -: SEL64_W]; // [RL5]
            segPick = segDesc64; // [RL5]
        end else begin
            segSelect = {{(SEL64_W-SEG_IDX_W){1'b0}},
                ea_ff[ADDR32_W-1 -: SEG_IDX_W]};
            segPick = {{(SEGID64_W-SEGID32_W){1'b0}},
                segRegs_ff[ea_ff[ADDR32_W-1 -: SEG_IDX_W]]}; // [RL9]
        end
    end

    // Entry screening against the search key
    always_comb begin
        if (WIDE64) begin
            entryMatch = memData[E64_VALID]
                && memData[E64_SEGID_LSB +: SEGID64_W] == segId_ff
                && memData[E64_ABPI_LSB +: ABPI64_W]
                    == pageKeyNow[ABPI64_W-1:0]
                && memData[E64_HSEL] == secondary_ff; // [RL14] [RL4] [RL8]
        end else begin
            entryMatch = memData[E32_VALID]
                && memData[E32_SEGID_LSB +: SEGID32_W]
                    == segId_ff[SEGID32_W-1:0]
                && memData[E32_ABPI_LSB +: ABPI32_W] == pageKeyNow
                && memData[E32_HSEL] == secondary_ff; // [RL14] [RL4] [RL12]
        end
    end

    assign lastEntry = (idx_ff == IDX_W'(GROUP_ENTRIES - 1));

    // Walker sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            HPT_IDLE: begin
                if (searchStart) begin
                    nxt_state = HPT_SEG;
                end
            end
            HPT_SEG: begin
                nxt_state = HPT_ADDR;
            end
            HPT_ADDR: begin
                nxt_state = HPT_READ;
            end
            HPT_READ: begin
                if (memAck) begin
                    if (entryMatch) begin
                        nxt_state = HPT_IDLE;
                    end else if (lastEntry) begin
                        // Second group only after a primary miss [RL17]
                        nxt_state = secondary_ff ? HPT_IDLE : HPT_ADDR;
                    end
                end
            end
            default: begin
                nxt_state = HPT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= HPT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Request capture: address at start, segment identifier one cycle on
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ea_ff <= '0;
            segId_ff <= '0;
        end else if (state_ff == HPT_IDLE && searchStart) begin
            ea_ff <= effAddr;
        end else if (state_ff == HPT_SEG) begin
            segId_ff <= segPick;
        end
    end

    // Group selector and entry index within the group
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            secondary_ff <= 1'b0;
            idx_ff <= '0;
        end else if (state_ff == HPT_IDLE) begin
            secondary_ff <= 1'b0;
            idx_ff <= '0;
        end else if (state_ff == HPT_READ && memAck && !entryMatch) begin
            idx_ff <= idx_ff + IDX_W'(1); // [RL15]
            if (lastEntry) begin
                secondary_ff <= 1'b1; // [RL17]
            end
        end
    end

    // Read address: group base, then one stride per entry
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memAddr_ff <= '0;
        end else if (state_ff == HPT_ADDR) begin
            memAddr_ff <= grpNow; // [RL17]
        end else if (state_ff == HPT_READ && memAck) begin
            memAddr_ff <= memAddr_ff + STRIDE;
        end
    end

    assign memReq = (state_ff == HPT_READ); // [RL17]
    assign memAddr = memAddr_ff;
    assign searchBusy = (state_ff != HPT_IDLE);

    // Outcome pulses; a fault only after both groups of eight missed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hit_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            hit_ff <= (state_ff == HPT_READ) && memAck && entryMatch;
            fault_ff <= (state_ff == HPT_READ) && memAck && !entryMatch
                && lastEntry && secondary_ff; // [RL15]
        end
    end

    // Captured hit entry and where it was found
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hitSec_ff <= 1'b0;
            hitData_ff <= '0;
            hitAddr_ff <= '0;
        end else if (state_ff == HPT_READ && memAck && entryMatch) begin
            hitSec_ff <= secondary_ff;
            hitData_ff <= memData;
            hitAddr_ff <= memAddr_ff;
        end
    end

    // Search addresses shown for software and debug
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            va_ff <= '0;
            priGrp_ff <= '0;
        end else if (state_ff == HPT_ADDR && !secondary_ff) begin
            va_ff <= vaNow;
            priGrp_ff <= grpNow;
        end
    end

    // Table geometry follows the descriptor every cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            base_ff <= '0;
            mergeCnt_ff <= '0;
        end else begin
            base_ff <= baseNow; // [RL1]
            mergeCnt_ff <= mergeNow; // [RL16]
        end
    end

    assign hitPulse = hit_ff;
    assign faultPulse = fault_ff;
    assign hitSecondary = hitSec_ff;
    assign hitEntryData = hitData_ff;
    assign hitEntryAddr = hitAddr_ff;
    assign virtAddr = va_ff;
    assign tableBase = base_ff;
    assign primaryGroupAddr = priGrp_ff;
    assign mergeBitCount = mergeCnt_ff;
    assign descReadback = desc_ff;
endmodule : hpt_addr_gen

// ===== hpt_addr_gen_properties.sv
// Port-level checks for the walker; layout checks are 32-bit except group alignment.
// Assumes binding into hpt_addr_gen with that module's WIDE64 value.
module hpt_addr_gen_properties import hpt_pkg::*; #(
    parameter bit WIDE64 = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic searchStart,
    input wire logic searchBusy,
    input wire logic memReq,
    input wire logic [hpt_pkg::PA_W-1:0] memAddr,
    input wire logic memAck,
    input wire logic hitPulse,
    input wire logic faultPulse,
    input wire logic hitSecondary,
    input wire logic [hpt_pkg::PA_W-1:0] hitEntryData,
    input wire logic [hpt_pkg::PA_W-1:0] tableBase,
    input wire logic [hpt_pkg::CNT_W-1:0] mergeBitCount,
    input wire logic [hpt_pkg::PA_W-1:0] descReadback
);
    timeunit 1ns;
    timeprecision 100ps;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Layout checks other than group alignment hold trivially in 64-bit instances; geometry outputs
    // trail the descriptor by one register, hence the past value
    chk_base_zeros: assert property (WIDE64 ||
        tableBase == {32'h0, $past(descReadback[31:16]), 16'h0})
        else $error("table base not origin over 16 zeros");
    // Strides move the low bits, so only a group's first read is checked
    chk_group_low: assert property ($rose(memReq) |->
        memAddr[5:0] == 6'h0 && (!WIDE64 || !memAddr[6]))
        else $error("group address low bits set");
    chk_hsel_match: assert property (hitPulse |-> WIDE64 ||
        hitEntryData[E32_HSEL] == hitSecondary)
        else $error("hit entry select bit does not suit group");
    chk_hit_valid: assert property (hitPulse |-> WIDE64 ||
        hitEntryData[E32_VALID]) else $error("hit on invalid entry");
    chk_hit_ack: assert property (hitPulse |-> $past(memAck))
        else $error("hit without a read answer");
    chk_one_result: assert property (hitPulse || faultPulse |=>
        !hitPulse && !faultPulse) else $error("result longer than a cycle");
    chk_req_busy: assert property (memReq |-> searchBusy)
        else $error("read request outside a search");
    chk_req_hold: assert property (memReq && !memAck |=>
        memReq && $stable(memAddr)) else $error("request dropped early");
    chk_start_busy: assert property (!searchBusy && searchStart |=>
        searchBusy [*2]) else $error("search not taken");
    chk_merge_width: assert property (WIDE64 ||
        mergeBitCount == $countones($past(descReadback[MASK32_W-1:0])))
        else $error("merged bit count wrong");
endmodule : hpt_addr_gen_properties

// ===== hpt_mem_model.sv
// Memory holding the table: one entry word answers a chosen address.
// Assumes the walker holds memReq and memAddr until memAck.
module hpt_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic memReq,
    input wire logic [hpt_pkg::PA_W-1:0] memAddr,
    output logic memAck,
    output logic [hpt_pkg::PA_W-1:0] memData,
    input wire logic [hpt_pkg::PA_W-1:0] hitAddr,
    input wire logic [hpt_pkg::PA_W-1:0] hitWord,
    input wire logic [hpt_pkg::PA_W-1:0] missWord,
    input wire logic [3:0] waitCycles
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] waitCnt_ff;
    // Answer after waitCycles idle cycles; data toggles when not valid
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memAck <= 1'b0;
            memData <= '0;
            waitCnt_ff <= '0;
        end else if (memReq && !memAck && waitCnt_ff == waitCycles) begin
            memAck <= 1'b1;
            waitCnt_ff <= '0;
            memData <= (memAddr == hitAddr) ? hitWord : missWord;
        end else begin
            memAck <= 1'b0;
            memData <= ~memData; // Stale data must not look valid
            if (memReq && !memAck) begin
                waitCnt_ff <= waitCnt_ff + 4'h1;
            end
        end
    end
endmodule : hpt_mem_model

// ===== tb.sv
// Self-checking bench for both walker widths and their memory models.
// Assumes the checker and model files are compiled before this one.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hpt_pkg::*;
    localparam logic [23:0] SEG_ID = 24'h5a3c71;
    localparam logic [51:0] SEG_ID64 = 52'h9_1b2c_3d4e_5f60;
    localparam logic [31:0] EA = 32'h3abcd123;
    localparam logic [63:0] DESC = 64'h0f980007; // Origin clear under mask
    localparam logic [63:0] DESC64 = 64'h0000_0012_3400_0004;
    logic clock = 0, rst = 1, segWrEn = 0, descWrEn = 0, searchStart = 0;
    logic [3:0] segWrIndex = '0, waitCycles = '0;
    logic [23:0] segWrData = '0;
    logic [63:0] descWrData = '0, effAddr = '0, hitAddr = '0;
    logic [63:0] hitWord = '0, missWord = '0, memAddr, memData;
    logic [63:0] hitEntryData, hitEntryAddr, tableBase;
    logic [63:0] primaryGroupAddr, descReadback;
    logic [79:0] virtAddr;
    logic [35:0] segSelect;
    logic [4:0] mergeBitCount;
    logic searchBusy, memReq, memAck, hitPulse, faultPulse, hitSecondary;
    logic gotHit, gotFault;
    logic [63:0] hitAddr64 = '0, hitWord64 = '0, missWord64 = '0;
    logic [63:0] memAddr64, memData64, hitData64, hitAt64, priGrp64;
    logic [63:0] tableBase64;
    logic [79:0] virtAddr64;
    logic [35:0] segSel64;
    logic [4:0] mergeCnt64;
    logic memReq64, memAck64, hitPulse64, faultPulse64;
    logic [1:0] res64 = '0;
    int bad_count = 0, tests_run = 0, reads = 0, cycles = 0;
    hpt_addr_gen #(.WIDE64(1'b0)) i_hpt_addr_gen (.clock(clock), .rst(rst),
        .segWrEn(segWrEn), .segWrIndex(segWrIndex), .segWrData(segWrData),
        .descWrEn(descWrEn), .descWrData(descWrData),
        .searchStart(searchStart), .effAddr(effAddr),
        .searchBusy(searchBusy), .segSelect(segSelect), .segDesc64(52'h0),
        .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memData(memData), .hitPulse(hitPulse), .faultPulse(faultPulse),
        .hitSecondary(hitSecondary), .hitEntryData(hitEntryData),
        .hitEntryAddr(hitEntryAddr), .virtAddr(virtAddr),
        .tableBase(tableBase), .primaryGroupAddr(primaryGroupAddr),
        .mergeBitCount(mergeBitCount), .descReadback(descReadback));
    hpt_mem_model i_hpt_mem_model (.clock(clock), .rst(rst),
        .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memData(memData), .hitAddr(hitAddr), .hitWord(hitWord),
        .missWord(missWord), .waitCycles(waitCycles));
    // Wide walker on the same requests; the segment lookup answers one
    // selector only, so a wrong pick shows up as a miss
    hpt_addr_gen #(.WIDE64(1'b1)) i_hpt_addr_gen64 (.clock(clock),
        .rst(rst), .segWrEn(1'b0), .segWrIndex(4'h0), .segWrData(24'h0),
        .descWrEn(descWrEn), .descWrData(DESC64),
        .searchStart(searchStart), .effAddr(effAddr), .searchBusy(),
        .segSelect(segSel64), .segDesc64(segSel64 == {32'h0, EA[31:28]}
        ? SEG_ID64 : ~SEG_ID64), .memReq(memReq64), .memAddr(memAddr64),
        .memAck(memAck64), .memData(memData64), .hitPulse(hitPulse64),
        .faultPulse(faultPulse64), .hitSecondary(), .hitEntryData(hitData64),
        .hitEntryAddr(hitAt64), .virtAddr(virtAddr64),
        .tableBase(tableBase64), .primaryGroupAddr(priGrp64),
        .mergeBitCount(mergeCnt64), .descReadback());
    hpt_mem_model i_hpt_mem_model64 (.clock(clock), .rst(rst),
        .memReq(memReq64), .memAddr(memAddr64), .memAck(memAck64),
        .memData(memData64), .hitAddr(hitAddr64), .hitWord(hitWord64),
        .missWord(missWord64), .waitCycles(waitCycles));
    // 200 MHz clock
    always #2.5 clock = ~clock;
    // Count taken reads; cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (memReq && memAck) reads++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    // Expected group address, worked out independently of the design
    function automatic logic [63:0] grp(input bit sec);
        logic [18:0] h;
        h = SEG_ID[18:0] ^ {3'h0, EA[27:12]};
        if (sec) h = ~h;
        return {32'h0, DESC[31:25], (h[18:10] & DESC[8:0]) | DESC[24:16],
            h[9:0], 6'h0};
    endfunction : grp
    function automatic logic [63:0] word(input bit h);
        return {32'h0, 1'b1, SEG_ID, h, EA[27:22]};
    endfunction : word
    // Wide group: low 11 hash bits plain, four more under the mask
    function automatic logic [63:0] grp64(input bit sec);
        logic [38:0] h;
        h = SEG_ID64[38:0] ^ {23'h0, EA[27:12]};
        if (sec) h = ~h;
        return {DESC64[63:36], DESC64[35:18] | {14'h0, h[14:11]}, h[10:0],
            7'h0};
    endfunction : grp64
    function automatic logic [63:0] word64(input bit h);
        return {SEG_ID64, EA[27:23], 5'h0, h, 1'b1};
    endfunction : word64
    task check(input string name, input logic [79:0] e, input logic [79:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : check
    task tick();
        @(posedge clock);
        #1;
    endtask : tick
    // Start one search and wait for its result; poke writes while busy
    task search(input bit poke);
        gotHit = 0;
        gotFault = 0;
        reads = 0;
        effAddr = {32'h0, EA};
        searchStart = 1;
        tick();
        searchStart = 0;
        for (int n = 0; n < 400 && !gotHit && !gotFault; n++) begin
            descWrEn = poke && (n == 2);
            tick();
            gotHit = (hitPulse === 1'b1);
            gotFault = (faultPulse === 1'b1);
            res64 = {faultPulse64 === 1'b1, hitPulse64 === 1'b1};
        end
        descWrEn = 0;
    endtask : search
    task scn_primary();
        hitAddr = grp(0);
        hitWord = word(0);
        hitAddr64 = grp64(0);
        hitWord64 = word64(0);
        search(0);
        check("hit", 1, gotHit);
        check("entry data", word(0), hitEntryData);
        check("seg select", {32'h0, EA[31:28]}, segSelect);
        check("wide result", 2'b01, res64);
        check("wide entry", word64(0), hitData64);
        check("wide entry addr", grp64(0), hitAt64);
        check("wide group", grp64(0), priGrp64);
        check("wide virt addr", {SEG_ID64, EA[27:0]}, virtAddr64);
        check("wide base", {DESC64[63:18], 18'h0}, tableBase64);
        check("wide merge", 4, mergeCnt64);
        check("wide select", {32'h0, EA[31:28]}, segSel64);
        check("entry addr", grp(0), hitEntryAddr);
        check("primary group", grp(0), primaryGroupAddr);
        check("virt addr", {28'h0, SEG_ID, EA[27:0]}, virtAddr);
        check("table base", {32'h0, DESC[31:16], 16'h0}, tableBase);
        check("merge count", 3, mergeBitCount);
        check("reads", 1, reads);
        check("secondary", 0, hitSecondary);
    endtask : scn_primary
    // Primary entries match but carry the select bit set
    task scn_secondary();
        hitAddr = grp(1);
        hitWord = word(1);
        missWord = word(1);
        hitAddr64 = grp64(1);
        hitWord64 = word64(1);
        missWord64 = word64(1);
        search(0);
        check("hit", 1, gotHit);
        check("secondary", 1, hitSecondary);
        check("entry addr", grp(1), hitEntryAddr);
        check("reads", 9, reads);
        check("wide result", 2'b01, res64);
        check("wide entry", word64(1), hitData64);
        check("wide entry addr", grp64(1), hitAt64);
    endtask : scn_secondary
    // Invalid entries, then an index bit outside the hash; slow memory
    task scn_fault();
        hitAddr = 64'h1;
        hitAddr64 = 64'h1;
        descWrData = 64'h0;
        for (int k = 0; k < 2; k++) begin
            missWord = word(0) ^ (k ? 64'h20 : 64'h80000000);
            // Top index bit lies outside the hash with four mask bits
            missWord64 = word64(0) ^ (k ? 64'h800 : 64'h1);
            waitCycles = 4'(k + 1);
            search(1);
            check("fault", 1, gotFault);
            check("hit", 0, gotHit);
            check("reads", 16, reads);
            check("desc kept", DESC, descReadback);
            check("wide result", 2'b10, res64);
        end
    endtask : scn_fault
    task final_report();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // Reset, program segments and descriptor, then run scenarios
    initial begin
        repeat (2) @(posedge clock);
        #1;
        rst = 0;
        for (int i = 2; i < 4; i++) begin
            segWrIndex = 4'(i);
            segWrData = (i == 3) ? SEG_ID : ~SEG_ID; // Wrong one must not win
            segWrEn = 1;
            tick();
        end
        segWrEn = 0;
        descWrData = DESC;
        descWrEn = 1;
        tick();
        descWrEn = 0;
        tick();
        scn_primary();
        scn_secondary();
        scn_fault();
        final_report();
    end
endmodule : tb

bind hpt_addr_gen hpt_addr_gen_properties #(.WIDE64(WIDE64)) i_props (
    .clock(clock), .rst(rst), .searchStart(searchStart),
    .searchBusy(searchBusy), .memReq(memReq), .memAddr(memAddr),
    .memAck(memAck), .hitPulse(hitPulse), .faultPulse(faultPulse),
    .hitSecondary(hitSecondary), .hitEntryData(hitEntryData),
    .tableBase(tableBase), .mergeBitCount(mergeBitCount),
    .descReadback(descReadback));
